/* File: hw/mtc_core.sv */
// Multimode 16-bit timer/counter core with APB register slave.
// Assumes APB master on pclk; clock sources arrive as pins from other domains.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`default_nettype none
`include "mtc_params.svh"

module mtc_core
    import mtc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic aux_clock_in,
    input wire logic subsystem_master_clock_in,
    input wire logic pin_timer_clock,
    input wire logic second_pin_clock,
    output logic irq
);
    mtc_ctrl_s ctrl_q, ctrl_d;
    logic [15:0] count_value_q, count_value_d;
    logic [15:0] period_q, period_d;
    mtc_flags_s flags_q, flags_d;
    logic down_q, down_d;
    logic [2:0] pre1_q, pre1_d;
    logic [2:0] pre2_q, pre2_d;
    logic [3:0] src_sync;
    logic pready_q;
    logic src_prev_q, src_prev_d;
    logic period_zero_q, period_zero_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic irq_q, irq_d;
    logic src_now, src_edge, tick, bus_wr, bus_rd, addr_ok;
    logic [2:0] div1_load;

    // Four source pins, two-stage synchronised before any use
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            logic raw, stage1_q, stage2_q;
            assign raw = (gi == 0) ? aux_clock_in :
                         (gi == 1) ? subsystem_master_clock_in :
                         (gi == 2) ? pin_timer_clock : second_pin_clock;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage1_q <= 1'b0;
                    stage2_q <= 1'b0;
                end else begin
                    stage1_q <= raw;
                    stage2_q <= stage1_q;
                end
            end
            assign src_sync[gi] = stage2_q;
        end
    endgenerate

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    function automatic logic [2:0] div1_top(input logic [1:0] sel);
        case (sel)
            2'h0: return 3'h0;
            2'h1: return 3'h1;
            2'h2: return 3'h3;
            default: return 3'h7;
        endcase
    endfunction

    always_comb begin
        src_now = src_sync[ctrl_q.src];
        src_edge = src_now && !src_prev_q;
        src_prev_d = src_now;
        bus_wr = psel && penable && pwrite;
        bus_rd = psel && !penable && !pwrite;
        addr_ok = addr_is(paddr, `MTC_CTRL_OFF) || addr_is(paddr, `MTC_COUNT_OFF) ||
                  addr_is(paddr, `MTC_PERIOD_OFF) || addr_is(paddr, `MTC_FLAGS_OFF);
        div1_load = div1_top(ctrl_q.div1);
        ctrl_d = ctrl_q;
        period_d = period_q;
        count_value_d = count_value_q;
        flags_d = flags_q;
        down_d = down_q;
        pre1_d = pre1_q;
        pre2_d = pre2_q;
        period_zero_d = period_q == 16'h0000;
        tick = 1'b0;
        // Cascaded down-counting dividers; a tick fires on a source edge that finds both already at zero
        if (src_edge && ctrl_q.mode != MTC_STOP) begin
            if (pre1_q == 3'h0) begin
                pre1_d = div1_load;
                if (pre2_q == 3'h0) begin
                    pre2_d = ctrl_q.div2;
                    tick = 1'b1;
                end else begin
                    pre2_d = pre2_q - 3'h1;
                end
            end else begin
                pre1_d = pre1_q - 3'h1;
            end
        end
        // Counter advance, only by counting do flags set
        if (tick) begin
            case (ctrl_q.mode)
                MTC_UP: begin
                    if (period_q == 16'h0000) begin
                        count_value_d = count_value_q;
                    end else if (count_value_q >= period_q) begin
                        count_value_d = 16'h0000;
                        if (count_value_q == period_q) begin
                            flags_d.wrap = 1'b1;
                        end
                    end else begin
                        count_value_d = count_value_q + 16'h0001;
                        if (count_value_q + 16'h0001 == period_q) begin
                            flags_d.match = 1'b1;
                        end
                    end
                end
                MTC_CONT: begin
                    count_value_d = count_value_q + 16'h0001;
                    if (count_value_q == `MTC_COUNT_MAX) begin
                        flags_d.wrap = 1'b1;
                    end
                    if (count_value_q + 16'h0001 == period_q) begin
                        flags_d.match = 1'b1;
                    end
                end
                MTC_UPDN: begin
                    if (period_q == 16'h0000) begin
                        count_value_d = count_value_q;
                    end else if (!down_q) begin
                        if (count_value_q >= period_q) begin
                            down_d = 1'b1;
                            count_value_d = count_value_q - 16'h0001;
                        end else begin
                            count_value_d = count_value_q + 16'h0001;
                            if (count_value_q + 16'h0001 == period_q) begin
                                flags_d.match = 1'b1;
                            end
                        end
                    end else begin
                        if (count_value_q <= 16'h0001) begin
                            count_value_d = 16'h0000;
                            down_d = 1'b0;
                            if (count_value_q == 16'h0001) begin
                                flags_d.wrap = 1'b1;
                            end
                        end else begin
                            count_value_d = count_value_q - 16'h0001;
                        end
                    end
                end
                default: count_value_d = count_value_q;
            endcase
        end
        // Bus writes; hardware set wins over software clear only if the flag was clear before
        if (bus_wr) begin
            if (addr_is(paddr, `MTC_CTRL_OFF)) begin
                ctrl_d = mtc_ctrl_s'(pwdata[11:0]);
                ctrl_d.clr = 1'b0;
            end
            if (addr_is(paddr, `MTC_COUNT_OFF)) begin
                count_value_d = pwdata[15:0];
            end
            if (addr_is(paddr, `MTC_PERIOD_OFF)) begin
                period_d = pwdata[15:0];
                if (period_q == 16'h0000 && pwdata[15:0] != 16'h0000 &&
                    (ctrl_q.mode == MTC_UP || ctrl_q.mode == MTC_UPDN)) begin
                    count_value_d = 16'h0000;
                    down_d = 1'b0;
                end
            end
            if (addr_is(paddr, `MTC_FLAGS_OFF)) begin
                flags_d.wrap = flags_d.wrap & ~(pwdata[`MTC_FLAG_WRAP_BIT] & ~flags_d.wrap
                               | pwdata[`MTC_FLAG_WRAP_BIT] & ~(tick & flags_d.wrap & ~flags_q.wrap));
                flags_d.match = flags_d.match & ~(pwdata[`MTC_FLAG_MATCH_BIT] &
                                ~(flags_d.match & ~flags_q.match));
            end
            if (addr_is(paddr, `MTC_CTRL_OFF) && pwdata[`MTC_CTRL_CLR_BIT]) begin
                count_value_d = 16'h0000;
                pre1_d = 3'h0;
                pre2_d = 3'h0;
                down_d = 1'b0;
            end
        end
        irq_d = (flags_d.wrap && ctrl_d.en_wrap) || (flags_d.match && ctrl_d.en_match);
        prdata_d = 32'h0000_0000;
        if (bus_rd) begin
            case (paddr)
                `MTC_CTRL_OFF: prdata_d = {20'h00000, ctrl_q};
                `MTC_COUNT_OFF: prdata_d = {16'h0000, count_value_q};
                `MTC_PERIOD_OFF: prdata_d = {16'h0000, period_q};
                `MTC_FLAGS_OFF: prdata_d = {30'h0, flags_q};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
        pslverr_d = psel && !penable && !addr_ok;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= mtc_ctrl_s'(12'(`MTC_CTRL_RST));
            pready_q <= 1'b1;
            period_q <= `MTC_PERIOD_RST;
            count_value_q <= 16'h0000;
            flags_q <= '0;
            down_q <= 1'b0;
            pre1_q <= 3'h0;
            pre2_q <= 3'h0;
            src_prev_q <= 1'b0;
            period_zero_q <= 1'b1;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            pready_q <= 1'b1;
            period_q <= period_d;
            count_value_q <= count_value_d;
            flags_q <= flags_d;
            down_q <= down_d;
            pre1_q <= pre1_d;
            pre2_q <= pre2_d;
            src_prev_q <= src_prev_d;
            period_zero_q <= period_zero_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
        end
    end

    // Setup cycle registers the answer; access phase completes at once
    always_comb begin
        pready = pready_q;
        prdata = prdata_q;
        pslverr = pslverr_q;
        irq = irq_q;
    end

    AST_STOP_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_q.mode == MTC_STOP && !bus_wr) |=> $stable(count_value_q))
        else $error("Count moved in stop mode");
    AST_UP_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_q.mode == MTC_UP && tick && !bus_wr && count_value_q == period_q
         && period_q != 16'h0000) |=> (count_value_q == 16'h0000 && flags_q.wrap))
        else $error("Up mode did not wrap at period");
    AST_CONT_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_q.mode == MTC_CONT && tick && !bus_wr && count_value_q == 16'hffff)
        |=> (count_value_q == 16'h0000 && flags_q.wrap))
        else $error("Continuous wrap missing");
    AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (bus_wr && paddr == `MTC_CTRL_OFF && pwdata[`MTC_CTRL_CLR_BIT])
        |=> (count_value_q == 16'h0000 && !down_q && pre1_q == 3'h0))
        else $error("Clear did not reset state");
    AST_SW_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (bus_wr && paddr == `MTC_COUNT_OFF) |=> count_value_q == $past(pwdata[15:0]))
        else $error("Count write not immediate");
    AST_NO_SW_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        (!tick && !flags_q.wrap) |=> !flags_q.wrap)
        else $error("Wrap flag set without counting");
    AST_UPDN_TURN: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_q.mode == MTC_UPDN && tick && !bus_wr && down_q && count_value_q == 16'h0001)
        |=> (!down_q && flags_q.wrap))
        else $error("Up/down turn at zero wrong");
    AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_q.match && !(bus_wr && paddr == `MTC_FLAGS_OFF)) |=> flags_q.match)
        else $error("Match flag dropped on its own");
    AST_DIR_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_q.mode == MTC_STOP && !bus_wr) |=> $stable(down_q))
        else $error("Direction changed while stopped");

    // Named steps reused by the multi-step checks below
    sequence s_up_tick;
        ctrl_q.mode == MTC_UP && tick && !bus_wr && period_q != 16'h0000;
    endsequence
    sequence s_updn_tick;
        ctrl_q.mode == MTC_UPDN && tick && !bus_wr && period_q != 16'h0000;
    endsequence
    sequence s_cont_tick;
        ctrl_q.mode == MTC_CONT && tick && !bus_wr;
    endsequence
    sequence s_at_zero;
        count_value_q == 16'h0000;
    endsequence

    AST_UP_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        s_up_tick ##0 (count_value_q < period_q)
        |=> count_value_q == $past(count_value_q) + 16'h0001)
        else $error("Up mode step wrong");

    AST_UP_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
        s_up_tick ##0 (count_value_q + 16'h0001 == period_q) |=> flags_q.match)
        else $error("Up mode match flag missing");

    AST_UP_ABOVE: assert property (@(posedge pclk) disable iff (!presetn)
        s_up_tick ##0 (count_value_q > period_q) |=> s_at_zero)
        else $error("Count above period did not roll");

    AST_CONT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        s_cont_tick |=> count_value_q == $past(count_value_q) + 16'h0001)
        else $error("Continuous step wrong");

    AST_CONT_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
        s_cont_tick ##0 (count_value_q + 16'h0001 == period_q) |=> flags_q.match)
        else $error("Continuous match flag missing");

    AST_UPDN_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
        s_updn_tick ##0 (!down_q && count_value_q + 16'h0001 == period_q)
        |=> flags_q.match)
        else $error("Up/down match flag missing");

    AST_UPDN_PEAK: assert property (@(posedge pclk) disable iff (!presetn)
        s_updn_tick ##0 (!down_q && count_value_q >= period_q) |=> down_q)
        else $error("Up/down did not turn at period");

    AST_UPDN_CLIMB: assert property (@(posedge pclk) disable iff (!presetn)
        s_updn_tick ##0 (!down_q && count_value_q < period_q)
        |=> (!down_q && count_value_q == $past(count_value_q) + 16'h0001))
        else $error("Up/down climb wrong");

    AST_UPDN_FALL: assert property (@(posedge pclk) disable iff (!presetn)
        s_updn_tick ##0 (down_q && count_value_q > 16'h0001)
        |=> (down_q && count_value_q == $past(count_value_q) - 16'h0001))
        else $error("Up/down descent wrong");

    AST_ZERO_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
        ((ctrl_q.mode == MTC_UP || ctrl_q.mode == MTC_UPDN) && period_zero_q
         && period_q == 16'h0000 && !bus_wr) |=> $stable(count_value_q))
        else $error("Zero period did not hold count");

    AST_NO_TICK_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.mode == MTC_STOP |-> !tick)
        else $error("Tick in stop mode");

    AST_MATCH_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
        (!tick && !flags_q.match) |=> !flags_q.match)
        else $error("Match flag set without counting");

    AST_CLEAR_PRESCALE: assert property (@(posedge pclk) disable iff (!presetn)
        (bus_wr && paddr == `MTC_CTRL_OFF && pwdata[`MTC_CTRL_CLR_BIT])
        |=> pre2_q == 3'h0)
        else $error("Clear left second divider running");

    AST_PRESCALE_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
        (src_edge && ctrl_q.mode != MTC_STOP && pre1_q != 3'h0 && !bus_wr)
        |=> pre1_q == $past(pre1_q) - 3'h1)
        else $error("First divider did not count down");
endmodule
`default_nettype wire

/* File: hw/mtc_params.svh */
// Constants for the multimode timer/counter core: register offsets, fields, resets.
// Assumes inclusion from the core module and the testbench only.
`ifndef MTC_PARAMS_SVH
`define MTC_PARAMS_SVH

`define MTC_CTRL_OFF 12'h000
`define MTC_COUNT_OFF 12'h004
`define MTC_PERIOD_OFF 12'h008
`define MTC_FLAGS_OFF 12'h00c

`define MTC_CTRL_MODE_LSB 0
`define MTC_CTRL_SRC_LSB 2
`define MTC_CTRL_DIV1_LSB 4
`define MTC_CTRL_DIV2_LSB 6
`define MTC_CTRL_CLR_BIT 9
`define MTC_CTRL_WEN_BIT 10
`define MTC_CTRL_MEN_BIT 11

`define MTC_FLAG_WRAP_BIT 0
`define MTC_FLAG_MATCH_BIT 1

`define MTC_CTRL_RST 32'h0000_0000
`define MTC_PERIOD_RST 16'h0000
`define MTC_COUNT_MAX 16'hffff

`endif

/* File: hw/mtc_pkg.sv */
// Types shared by the multimode timer/counter core.
// Assumes mtc_params.svh is on the include path.
`default_nettype none
package mtc_pkg;
    typedef enum logic [1:0] {MTC_STOP, MTC_UP, MTC_CONT, MTC_UPDN} mtc_mode_e;
    typedef enum logic [1:0] {MTC_SRC_AUX, MTC_SRC_SMC, MTC_SRC_PIN, MTC_SRC_PIN2} mtc_src_e;
    typedef struct packed {
        logic       en_match;
        logic       en_wrap;
        logic       clr;
        logic [2:0] div2;
        logic [1:0] div1;
        mtc_src_e   src;
        mtc_mode_e  mode;
    } mtc_ctrl_s;
    typedef struct packed {
        logic match;
        logic wrap;
    } mtc_flags_s;
endpackage
`default_nettype wire

/* File: test/mtc_tb.sv */
// Self-checking bench for the multimode timer/counter core.
// Assumes the core's APB slave on pclk and four slow clock source pins driven here.
`default_nettype none
`include "mtc_params.svh"
module testbench
    import mtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [3:0] src_q = 4'h0;
    logic [31:0] rd;
    logic sl;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 pclk = ~pclk;

    mtc_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .aux_clock_in(src_q[0]), .subsystem_master_clock_in(src_q[1]),
        .pin_timer_clock(src_q[2]), .second_pin_clock(src_q[3]), .irq(irq));

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole run needs about 1300 cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, entered just after a rising edge; ends one idle cycle later
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    function automatic logic [31:0] cw(input mtc_mode_e m, input logic [1:0] s,
        input logic [1:0] d1, input logic [2:0] d2, input logic clr, input logic [1:0] en);
        mtc_ctrl_s c;
        c = '0;
        c.mode = m;
        c.src = mtc_src_e'(s);
        c.div1 = d1;
        c.div2 = d2;
        c.clr = clr;
        {c.en_match, c.en_wrap} = en;
        return {20'h00000, c};
    endfunction

    // Source pulses: 4 cycles high, 4 low, well below pclk/2
    task automatic tick(input int s, input int n);
        repeat (n) begin
            src_q[s] <= 1'b1;
            repeat (4) @(posedge pclk);
            src_q[s] <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    task automatic t_reset();
        rdc(`MTC_CTRL_OFF, 32'h0000_0000);
        rdc(`MTC_COUNT_OFF, 32'h0000_0000);
        rdc(`MTC_PERIOD_OFF, 32'h0000_0000);
        rdc(`MTC_FLAGS_OFF, 32'h0000_0000);
        rdc(12'h010, 32'h0000_0000);
        chk({31'h0, sl}, 32'h1);
    endtask

    task automatic t_up();
        wr(`MTC_PERIOD_OFF, 32'h3);
        wr(`MTC_CTRL_OFF, cw(MTC_UP, 2'd0, 2'd0, 3'd0, 1'b1, 2'b01));
        tick(0, 3);
        rdc(`MTC_COUNT_OFF, 32'h3);
        rdc(`MTC_FLAGS_OFF, 32'h2);
        chk({31'h0, irq}, 32'h0);
        tick(0, 1);
        rdc(`MTC_COUNT_OFF, 32'h0);
        rdc(`MTC_FLAGS_OFF, 32'h3);
        chk({31'h0, irq}, 32'h1);
        wr(`MTC_FLAGS_OFF, 32'h3);
        rdc(`MTC_FLAGS_OFF, 32'h0);
        chk({31'h0, irq}, 32'h0);
        tick(0, 3);
        wr(`MTC_PERIOD_OFF, 32'h1);
        tick(0, 1);
        rdc(`MTC_COUNT_OFF, 32'h0);
        tick(0, 1);
        wr(`MTC_PERIOD_OFF, 32'h0);
        tick(0, 2);
        rdc(`MTC_COUNT_OFF, 32'h1);
        wr(`MTC_PERIOD_OFF, 32'h4);
        tick(0, 2);
        rdc(`MTC_COUNT_OFF, 32'h2);
        wr(`MTC_CTRL_OFF, cw(MTC_STOP, 2'd0, 2'd0, 3'd0, 1'b0, 2'b00));
        tick(0, 2);
        rdc(`MTC_COUNT_OFF, 32'h2);
        wr(`MTC_FLAGS_OFF, 32'h3);
        wr(`MTC_COUNT_OFF, 32'h4);
        rdc(`MTC_COUNT_OFF, 32'h4);
        rdc(`MTC_FLAGS_OFF, 32'h0);
        wr(`MTC_COUNT_OFF, 32'h9);
        wr(`MTC_CTRL_OFF, cw(MTC_UP, 2'd0, 2'd0, 3'd0, 1'b0, 2'b00));
        tick(0, 1);
        rdc(`MTC_COUNT_OFF, 32'h0);
    endtask

    task automatic t_cont();
        wr(`MTC_PERIOD_OFF, 32'h5);
        wr(`MTC_COUNT_OFF, 32'h3);
        wr(`MTC_CTRL_OFF, cw(MTC_CONT, 2'd0, 2'd0, 3'd0, 1'b0, 2'b00));
        tick(0, 4);
        rdc(`MTC_COUNT_OFF, 32'h7);
        wr(`MTC_COUNT_OFF, 32'hfffe);
        tick(0, 1);
        rdc(`MTC_COUNT_OFF, 32'hffff);
        wr(`MTC_FLAGS_OFF, 32'h3);
        tick(0, 1);
        rdc(`MTC_COUNT_OFF, 32'h0);
        rdc(`MTC_FLAGS_OFF, 32'h1);
    endtask

    task automatic t_updn();
        wr(`MTC_PERIOD_OFF, 32'h2);
        wr(`MTC_CTRL_OFF, cw(MTC_UPDN, 2'd0, 2'd0, 3'd0, 1'b1, 2'b10));
        wr(`MTC_FLAGS_OFF, 32'h3);
        tick(0, 2);
        rdc(`MTC_FLAGS_OFF, 32'h2);
        chk({31'h0, irq}, 32'h1);
        tick(0, 1);
        rdc(`MTC_COUNT_OFF, 32'h1);
        wr(`MTC_CTRL_OFF, cw(MTC_STOP, 2'd0, 2'd0, 3'd0, 1'b0, 2'b00));
        tick(0, 2);
        wr(`MTC_CTRL_OFF, cw(MTC_UPDN, 2'd0, 2'd0, 3'd0, 1'b0, 2'b00));
        tick(0, 1);
        rdc(`MTC_COUNT_OFF, 32'h0);
        rdc(`MTC_FLAGS_OFF, 32'h3);
        tick(0, 1);
        wr(`MTC_CTRL_OFF, cw(MTC_UPDN, 2'd0, 2'd0, 3'd0, 1'b1, 2'b00));
        tick(0, 2);
        rdc(`MTC_COUNT_OFF, 32'h2);
    endtask

    task automatic t_div();
        logic [1:0] d1[4] = '{2'd0, 2'd1, 2'd2, 2'd3};
        logic [2:0] d2[4] = '{3'd6, 3'd0, 3'd1, 3'd7};
        int r;
        for (int i = 0; i < 4; i++) begin
            r = (1 << i) * (d2[i] + 1);
            wr(`MTC_CTRL_OFF, cw(MTC_CONT, 2'd0, d1[i], d2[i], 1'b1, 2'b00));
            tick(0, 1);
            rdc(`MTC_COUNT_OFF, 32'h1);
            tick(0, r - 1);
            rdc(`MTC_COUNT_OFF, 32'h1);
            tick(0, 1);
            rdc(`MTC_COUNT_OFF, 32'h2);
        end
    endtask

    task automatic t_src();
        for (int s = 0; s < 4; s++) begin
            wr(`MTC_CTRL_OFF, cw(MTC_CONT, 2'(s), 2'd0, 3'd0, 1'b1, 2'b00));
            tick((s + 1) % 4, 2);
            rdc(`MTC_COUNT_OFF, 32'h0);
            tick(s, 1);
            rdc(`MTC_COUNT_OFF, 32'h1);
        end
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_up();
        t_cont();
        t_updn();
        t_div();
        t_src();
        stop_test();
    end
endmodule
`default_nettype wire
